// ===== sfa_status_aggregator.sv
// Status flag aggregator: reduces fault and condition fields into summary and alert bits.
// Assumes flag sources are asynchronous levels and the host issues one field command at a time.
`timescale 1ns/1ps
`include "sfa_params.svh"

module sfa_status_aggregator
  import sfa_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Raw fault sources.
  input wire logic [15:0] i_algo_fault_flags,
  input wire logic i_cal_checksum_bad,
  input wire logic i_cal_altered,
  input wire logic i_iron_params_out_of_limits,
  // Raw condition sources.
  input wire logic [15:0] i_hw_condition,
  input wire logic [15:0] i_link_condition,
  input wire logic [15:0] i_sw_condition,
  input wire logic [15:0] i_sensor_condition,
  // Field command port.
  input wire logic i_field_req,
  input wire logic i_field_write,
  input wire logic [15:0] i_field_id,
  input wire logic [15:0] i_field_wdata,
  output logic o_field_ack,
  output logic o_field_err,
  output logic [15:0] o_field_rdata,
  // Summary outputs.
  output logic [15:0] o_algo_fault_flags,
  output logic [15:0] o_data_fault_flags,
  output logic [15:0] o_sw_fault_field,
  output logic o_algo_fault_summary,
  output logic o_data_fault_summary,
  output logic o_sw_fault_summary,
  output logic o_hw_alert,
  output logic o_link_alert,
  output logic o_sw_alert,
  output logic o_sensor_alert,
  output logic o_top_alert,
  output logic [15:0] o_top_health_word
);

  // Masked reduction shared by the four condition categories.
  function automatic logic masked_any(input sfa_word_t cond, input sfa_word_t mask,
                                      input sfa_word_t valid);
    masked_any = |(cond & mask & valid);
  endfunction : masked_any

  // Maps a field identifier onto a mask index; valid is low for unknown identifiers.
  function automatic logic [2:0] decode_id(input sfa_word_t id);
    case (id)
      `SFA_FID_HW_MASK: decode_id = 3'b100;
      `SFA_FID_LINK_MASK: decode_id = 3'b101;
      `SFA_FID_SW_MASK: decode_id = 3'b110;
      `SFA_FID_SENSOR_MASK: decode_id = 3'b111;
      default: decode_id = 3'b000;
    endcase
  endfunction : decode_id

  // Places the summaries in the top-level health word; every other bit stays zero.
  function automatic sfa_word_t pack_health(input logic sw_fault, input logic top,
                                            input logic [3:0] cat);
    sfa_word_t word;
    word = `SFA_WORD_RESET;
    word[`SFA_HW_SW_FAULT] = sw_fault;
    word[`SFA_HW_TOP_ALERT] = top;
    word[`SFA_HW_HW_ALERT] = cat[0];
    word[`SFA_HW_LINK_ALERT] = cat[1];
    word[`SFA_HW_SW_ALERT] = cat[2];
    word[`SFA_HW_SENSOR_ALERT] = cat[3];
    pack_health = word;
  endfunction : pack_health

  logic [15:0] algo_s;
  logic [2:0] data_s;
  logic [15:0] hw_s;
  logic [15:0] link_s;
  logic [15:0] sw_s;
  logic [15:0] sensor_s;

  // Every flag bus comes from other clocks, so it passes two flip-flops before use.
  sfa_input_sync #(.WIDTH(16)) u_sync_algo (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_algo_fault_flags),
    .o_sync(algo_s)
  );

  sfa_input_sync #(.WIDTH(3)) u_sync_data (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_cal_altered, i_iron_params_out_of_limits, i_cal_checksum_bad}),
    .o_sync(data_s)
  );

  sfa_input_sync #(.WIDTH(16)) u_sync_hw (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_hw_condition),
    .o_sync(hw_s)
  );

  sfa_input_sync #(.WIDTH(16)) u_sync_link (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_link_condition),
    .o_sync(link_s)
  );

  sfa_input_sync #(.WIDTH(16)) u_sync_sw (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_sw_condition),
    .o_sync(sw_s)
  );

  sfa_input_sync #(.WIDTH(16)) u_sync_sensor (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async(i_sensor_condition),
    .o_sync(sensor_s)
  );

  // Field command handling.
  logic [2:0] dec;
  logic wr_en;
  sfa_word_t rd_data;
  sfa_word_t mask_hw;
  sfa_word_t mask_link;
  sfa_word_t mask_sw;
  sfa_word_t mask_sensor;
  sfa_cmd_state_e cmd_state;
  logic pend_err;

  assign dec = decode_id(i_field_id);
  // A request is taken only in idle, so each command is answered once.
  assign wr_en = i_field_req && i_field_write && dec[2] && (cmd_state == SFA_CMD_IDLE);

  // Writes land at the taking edge, so a new mask steers the alerts from the answer cycle on.
  sfa_mask_store u_masks (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_wr_en(wr_en),
    .i_wr_sel(dec[1:0]),
    .i_wr_data(i_field_wdata),
    .i_rd_sel(dec[1:0]),
    .o_rd_data(rd_data),
    .o_mask_hw(mask_hw),
    .o_mask_link(mask_link),
    .o_mask_sw(mask_sw),
    .o_mask_sensor(mask_sensor)
  );

  // A request in the answer cycle is ignored, so commands must be two cycles apart.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_state <= SFA_CMD_IDLE;
      pend_err <= 1'b0;
    end else begin
      case (cmd_state)
        SFA_CMD_IDLE: begin
          if (i_field_req) begin
            cmd_state <= SFA_CMD_ANSWER;
            pend_err <= ~dec[2];
          end
        end
        SFA_CMD_ANSWER: begin
          cmd_state <= SFA_CMD_IDLE;
        end
        default: begin
          cmd_state <= SFA_CMD_IDLE;
        end
      endcase
    end
  end

  // Answer appears two edges after the request and stands for one cycle.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_field_ack <= 1'b0;
      o_field_err <= 1'b0;
    end else begin
      o_field_ack <= (cmd_state == SFA_CMD_ANSWER);
      o_field_err <= (cmd_state == SFA_CMD_ANSWER) && pend_err;
    end
  end

  // Read data come from the mask store and hold until the next answer; an unknown
  // identifier answers with zero so no stale mask can pass for the requested one.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_field_rdata <= `SFA_WORD_RESET;
    end else if (cmd_state == SFA_CMD_ANSWER) begin
      o_field_rdata <= pend_err ? `SFA_WORD_RESET : rd_data;
    end
  end

  // Fault fields and summaries.
  sfa_word_t algo_f;
  sfa_word_t data_f;
  logic algo_sum;
  logic data_sum;
  logic sw_sum;

  // A calibration altered after a write enable reads the same as a bad checksum.
  assign algo_f = algo_s & `SFA_ALGO_VALID;
  assign data_f = {14'h0000, data_s[1], data_s[0] | data_s[2]} & `SFA_DATA_VALID;
  assign algo_sum = |algo_f;
  assign data_sum = |data_f;
  assign sw_sum = algo_sum | data_sum;

  logic hw_a;
  logic link_a;
  logic sw_a;
  logic sensor_a;
  logic top_a;

  // The valid masks drop reserved positions, so a stray reserved bit never raises an alert.
  assign hw_a = masked_any(hw_s, mask_hw, `SFA_HW_VALID);
  assign link_a = masked_any(link_s, mask_link, `SFA_LINK_VALID);
  assign sw_a = masked_any(sw_s, mask_sw, `SFA_SW_VALID);
  assign sensor_a = masked_any(sensor_s, mask_sensor, `SFA_SENSOR_VALID);
  assign top_a = hw_a | link_a | sw_a | sensor_a;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_algo_fault_flags <= `SFA_WORD_RESET;
      o_data_fault_flags <= `SFA_WORD_RESET;
      o_sw_fault_field <= `SFA_WORD_RESET;
    end else begin
      o_algo_fault_flags <= algo_f;
      o_data_fault_flags <= data_f;
      o_sw_fault_field <= {14'h0000, data_sum, algo_sum};
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_algo_fault_summary <= 1'b0;
      o_data_fault_summary <= 1'b0;
      o_sw_fault_summary <= 1'b0;
    end else begin
      o_algo_fault_summary <= algo_sum;
      o_data_fault_summary <= data_sum;
      o_sw_fault_summary <= sw_sum;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hw_alert <= 1'b0;
      o_link_alert <= 1'b0;
      o_sw_alert <= 1'b0;
      o_sensor_alert <= 1'b0;
    end else begin
      o_hw_alert <= hw_a;
      o_link_alert <= link_a;
      o_sw_alert <= sw_a;
      o_sensor_alert <= sensor_a;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_top_alert <= 1'b0;
    end else begin
      o_top_alert <= top_a;
    end
  end

  // Top-level health word; failure bits other than the software one belong elsewhere.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_top_health_word <= `SFA_WORD_RESET;
    end else begin
      o_top_health_word <= pack_health(sw_sum, top_a, {sensor_a, sw_a, link_a, hw_a});
    end
  end

endmodule : sfa_status_aggregator

// ===== sfa_params.svh
// Constants for the status flag aggregator: field identifiers, bit positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef SFA_PARAMS_SVH
`define SFA_PARAMS_SVH

`define SFA_FID_HW_MASK 16'h0010
`define SFA_FID_LINK_MASK 16'h0011
`define SFA_FID_SW_MASK 16'h0012
`define SFA_FID_SENSOR_MASK 16'h0013

`define SFA_ALGO_VALID 16'h0007
`define SFA_DATA_VALID 16'h0003
`define SFA_HW_VALID 16'h000F
`define SFA_LINK_VALID 16'h0001
`define SFA_SW_VALID 16'h000F
`define SFA_SENSOR_VALID 16'h0001

`define SFA_BIT_INIT_ERR 0
`define SFA_BIT_OVER_LIMIT 1
`define SFA_BIT_NAV_DEADLINE 2
`define SFA_BIT_CAL_CHECKSUM 0
`define SFA_BIT_IRON_LIMITS 1
`define SFA_BIT_CAL_STORE_WRITABLE 3
`define SFA_BIT_NO_OUTSIDE_GNSS 0

`define SFA_HW_SW_FAULT 3
`define SFA_HW_TOP_ALERT 8
`define SFA_HW_HW_ALERT 9
`define SFA_HW_LINK_ALERT 10
`define SFA_HW_SW_ALERT 11
`define SFA_HW_SENSOR_ALERT 12

`define SFA_MASK_RESET 16'h0000
`define SFA_WORD_RESET 16'h0000

`endif

// ===== sfa_pkg.sv
// Types shared by the status flag aggregator modules.
// Assumes sfa_params.svh is on the include path.
`include "sfa_params.svh"

package sfa_pkg;

  typedef logic [15:0] sfa_word_t;
  typedef logic [1:0] sfa_mask_sel_t;

  typedef enum logic [1:0] {
    SFA_CMD_IDLE,
    SFA_CMD_ANSWER
  } sfa_cmd_state_e;

endpackage : sfa_pkg

// ===== sfa_mask_store.sv
// Four sixteen-bit enable masks held in a small register array.
// Assumes the caller decodes field identifiers into a two-bit index.
`timescale 1ns/1ps
`include "sfa_params.svh"

module sfa_mask_store
  import sfa_pkg::*;
(
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Write port.
  input wire logic i_wr_en,
  input wire sfa_mask_sel_t i_wr_sel,
  input wire sfa_word_t i_wr_data,
  // Registered read port.
  input wire sfa_mask_sel_t i_rd_sel,
  output sfa_word_t o_rd_data,
  // All masks in parallel for the alert logic.
  output sfa_word_t o_mask_hw,
  output sfa_word_t o_mask_link,
  output sfa_word_t o_mask_sw,
  output sfa_word_t o_mask_sensor
);

  sfa_word_t mem [4];

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        mem[i] <= `SFA_MASK_RESET;
      end
    end else if (i_wr_en) begin
      mem[i_wr_sel] <= i_wr_data;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= `SFA_MASK_RESET;
    end else begin
      o_rd_data <= mem[i_rd_sel];
    end
  end

  assign o_mask_hw = mem[0];
  assign o_mask_link = mem[1];
  assign o_mask_sw = mem[2];
  assign o_mask_sensor = mem[3];

endmodule : sfa_mask_store

// ===== sfa_input_sync.sv
// Two-stage synchroniser for a bus of condition and fault levels from other logic.
// Assumes each bit is an independent slow level.
`timescale 1ns/1ps

module sfa_input_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Levels in and out.
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule : sfa_input_sync

// ===== sfa_status_aggregator_checker.sv
// Port checker for the status flag aggregator.
// Assumes it is bound onto sfa_status_aggregator.
`timescale 1ns/1ps

module sfa_status_aggregator_checker (
  // Clock, reset and field port.
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_field_req,
  input wire logic o_field_ack,
  input wire logic o_field_err,
  input wire logic [15:0] o_field_rdata,
  // Summaries and alerts.
  input wire logic [15:0] o_algo_fault_flags,
  input wire logic [15:0] o_data_fault_flags,
  input wire logic [15:0] o_sw_fault_field,
  input wire logic o_algo_fault_summary,
  input wire logic o_data_fault_summary,
  input wire logic o_sw_fault_summary,
  input wire logic o_hw_alert,
  input wire logic o_link_alert,
  input wire logic o_sw_alert,
  input wire logic o_sensor_alert,
  input wire logic o_top_alert,
  input wire logic [15:0] o_top_health_word
);
  logic busy;

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      busy <= 1'b0;
    end else begin
      busy <= i_field_req && !busy;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_take;
    i_field_req && !busy;
  endsequence
  sequence s_answer;
    o_field_ack ##1 !o_field_ack;
  endsequence

  AST_ACK_TIMING: assert property (s_take |-> ##2 s_answer)
    else $error("field answer mistimed");
  AST_ACK_CAUSE: assert property (o_field_ack |-> $past(busy))
    else $error("field answer without request");
  AST_ERR_PAIR: assert property (o_field_err |-> o_field_ack && o_field_rdata == 16'h0000)
    else $error("error answer malformed");
  AST_ALGO_OR: assert property (o_algo_fault_summary == (|o_algo_fault_flags))
    else $error("algorithm summary wrong");
  AST_DATA_OR: assert property (o_data_fault_summary == (|o_data_fault_flags))
    else $error("data summary wrong");
  AST_RSVD: assert property (o_algo_fault_flags[15:3] == 13'h0 && o_data_fault_flags[15:2] == 14'h0)
    else $error("reserved fault bit set");
  AST_SW_FIELD: assert property (o_sw_fault_field == {14'h0, o_data_fault_summary,
      o_algo_fault_summary} && o_sw_fault_summary == (|o_sw_fault_field))
    else $error("software fault field wrong");
  AST_TOP_OR: assert property (o_top_alert == (o_hw_alert | o_link_alert | o_sw_alert | o_sensor_alert))
    else $error("top alert wrong");
  AST_WORD_MAP: assert property (o_top_health_word[12:8] == {o_sensor_alert, o_sw_alert,
      o_link_alert, o_hw_alert, o_top_alert} && o_top_health_word[3] == o_sw_fault_summary)
    else $error("health word map wrong");
endmodule : sfa_status_aggregator_checker

bind sfa_status_aggregator sfa_status_aggregator_checker u_chk (
  .i_sys_clk, .i_rst, .i_field_req, .o_field_ack, .o_field_err, .o_field_rdata,
  .o_algo_fault_flags, .o_data_fault_flags, .o_sw_fault_field, .o_algo_fault_summary,
  .o_data_fault_summary, .o_sw_fault_summary, .o_hw_alert, .o_link_alert, .o_sw_alert,
  .o_sensor_alert, .o_top_alert, .o_top_health_word
);

// ===== sfa_host_model.sv
// Host issuing field read and write commands.
// Assumes the bench calls field_cmd and checks the answers itself.
`timescale 1ns/1ps

module sfa_host_model (
  // Clock.
  input wire logic i_sys_clk,
  // Command lines.
  output logic o_field_req,
  output logic o_field_write,
  output logic [15:0] o_field_id,
  output logic [15:0] o_field_wdata
);
  initial begin
    o_field_req = 1'b0;
    o_field_write = 1'b0;
    o_field_id = 16'h0000;
    o_field_wdata = 16'h0000;
  end

  // Released lines are inverted so a stale id or word cannot pass for a fresh one.
  task automatic field_cmd(input logic wr, input logic [15:0] id, input logic [15:0] dat,
                           input int gap);
    @(negedge i_sys_clk);
    o_field_req = 1'b1;
    o_field_write = wr;
    o_field_id = id;
    o_field_wdata = dat;
    @(negedge i_sys_clk);
    o_field_req = 1'b0;
    o_field_id = ~id;
    o_field_wdata = ~dat;
    repeat (gap) @(negedge i_sys_clk);
  endtask : field_cmd
endmodule : sfa_host_model

// ===== sfa_status_aggregator_tb.sv
// Self-checking bench for the status flag aggregator.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
`include "sfa_params.svh"

module sfa_status_aggregator_tb
  import sfa_pkg::*;
;
  logic i_sys_clk, i_rst, i_cal_checksum_bad, i_cal_altered, i_iron_params_out_of_limits;
  sfa_word_t i_algo_fault_flags, i_hw_condition, i_link_condition, i_sw_condition;
  sfa_word_t i_sensor_condition, i_field_id, i_field_wdata, o_field_rdata, a, d;
  logic i_field_req, i_field_write, o_field_ack, o_field_err;
  sfa_word_t o_algo_fault_flags, o_data_fault_flags, o_sw_fault_field, o_top_health_word;
  logic o_algo_fault_summary, o_data_fault_summary, o_sw_fault_summary, o_top_alert;
  logic o_hw_alert, o_link_alert, o_sw_alert, o_sensor_alert;
  logic [3:0] al;
  logic [17:0] note;
  logic [17:0] exp_q [$];
  sfa_word_t mask [4];
  int err_total, n_compared;
  int seed = 32'h3eb75419;

  sfa_status_aggregator u_dut (
    .i_sys_clk, .i_rst, .i_algo_fault_flags, .i_cal_checksum_bad, .i_cal_altered,
    .i_iron_params_out_of_limits, .i_hw_condition, .i_link_condition, .i_sw_condition,
    .i_sensor_condition, .i_field_req, .i_field_write, .i_field_id, .i_field_wdata,
    .o_field_ack, .o_field_err, .o_field_rdata, .o_algo_fault_flags, .o_data_fault_flags,
    .o_sw_fault_field, .o_algo_fault_summary, .o_data_fault_summary, .o_sw_fault_summary,
    .o_hw_alert, .o_link_alert, .o_sw_alert, .o_sensor_alert, .o_top_alert, .o_top_health_word
  );
  sfa_host_model u_host (.i_sys_clk, .o_field_req(i_field_req), .o_field_write(i_field_write),
    .o_field_id(i_field_id), .o_field_wdata(i_field_wdata));

  initial begin
    i_sys_clk = 1'b0;
    forever #10 i_sys_clk = ~i_sys_clk;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    check("pending answers", 16'h0000, 16'(exp_q.size()));
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic cmd(input logic wr, input int k, input sfa_word_t v, input logic [17:0] n);
    exp_q.push_back(n);
    u_host.field_cmd(wr, `SFA_FID_HW_MASK + 16'(k), v, k % 2);
  endtask : cmd

  task automatic read_all();
    for (int k = 0; k < 4; k++) cmd(1'b0, k, 16'h0000, {2'b10, mask[k]});
  endtask : read_all

  // Takes the oldest note whenever the device answers.
  always @(negedge i_sys_clk) begin
    if (o_field_ack === 1'b1) begin
      check("answer expected", 16'h0001, {15'h0, exp_q.size() != 0});
      note = exp_q.pop_front();
      check("field err", {15'h0, note[16]}, {15'h0, o_field_err});
      if (note[17]) check("field rdata", note[15:0], o_field_rdata);
    end
  end

  initial begin
    #(20 * 20000);
    err_total++;
    give_verdict();
  end

  initial begin
    {i_algo_fault_flags, i_hw_condition, i_link_condition, i_sw_condition} = '0;
    {i_sensor_condition, i_cal_checksum_bad, i_cal_altered, i_iron_params_out_of_limits} = '0;
    mask = '{default: 16'h0000};
    i_rst = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    i_rst = 1'b0;
    read_all();
    $display("test reset_masks done");
    for (int n = 0; n < 40; n++) begin
      for (int k = 0; k < 4; k++) begin
        mask[k] = 16'($random(seed));
        cmd(1'b1, k, mask[k], 18'h0_0000);
      end
      cmd(n[0], 4 + n % 8, 16'hffff, {2'b11, 16'h0000});
      read_all();
      i_algo_fault_flags = 16'($random(seed) & $random(seed));
      {i_cal_checksum_bad, i_cal_altered, i_iron_params_out_of_limits} = 3'($random(seed));
      i_hw_condition = 16'($random(seed) & $random(seed) & $random(seed));
      i_link_condition = 16'($random(seed) & $random(seed));
      i_sw_condition = 16'($random(seed) & $random(seed) & $random(seed));
      i_sensor_condition = 16'($random(seed) & $random(seed));
      repeat (4) @(negedge i_sys_clk);
      a = i_algo_fault_flags & `SFA_ALGO_VALID;
      d = {14'h0, i_iron_params_out_of_limits, i_cal_checksum_bad | i_cal_altered};
      al = {|(i_sensor_condition & mask[3] & `SFA_SENSOR_VALID),
            |(i_sw_condition & mask[2] & `SFA_SW_VALID),
            |(i_link_condition & mask[1] & `SFA_LINK_VALID),
            |(i_hw_condition & mask[0] & `SFA_HW_VALID)};
      check("algo flags", a, o_algo_fault_flags);
      check("data flags", d, o_data_fault_flags);
      check("sw field", {14'h0, |d, |a}, o_sw_fault_field);
      check("summaries", {13'h0, |{a, d}, |d, |a}, {13'h0, o_sw_fault_summary,
        o_data_fault_summary, o_algo_fault_summary});
      check("alerts", {11'h0, |al, al}, {11'h0, o_top_alert, o_sensor_alert, o_sw_alert,
        o_link_alert, o_hw_alert});
      check("health", {3'h0, al, |al, 4'h0, |{a, d}, 3'h0}, o_top_health_word);
    end
    $display("test random_flags done");
    i_rst = 1'b1;
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    mask = '{default: 16'h0000};
    read_all();
    repeat (3) @(negedge i_sys_clk);
    $display("test second_reset done");
    give_verdict();
  end
endmodule : sfa_status_aggregator_tb
